/* common/aps_consts.svh */
// constants for the converter power shutdown control
`ifndef APS_CONSTS_SVH
`define APS_CONSTS_SVH
`define APS_CFG_BITS   8
`define APS_SD_EDGE    10
`define APS_LEN_SD     2'h1
`define APS_CONV_NS    13000
`define APS_CLK_NS     20
`define APS_CONV_CYC   ((`APS_CONV_NS + `APS_CLK_NS - 1) / `APS_CLK_NS)
`endif

/* common/aps_pkg.sv */
// types for the converter power shutdown control
package aps_pkg;
    typedef struct packed {
        logic       single_end;
        logic       odd_sign;
        logic [1:0] chan_sel;
        logic       unipolar;
        logic       msb_first;
        logic       length_sel_hi;
        logic       length_sel_lo;
    } aps_cfg_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_DUMMY,
        ST_DOWN
    } aps_state_t;
endpackage : aps_pkg

/* logic/aps_shutdown.sv */
// power shutdown control: serial config capture on the shift clock, power state on clk
`include "aps_consts.svh"
module aps_shutdown
    import aps_pkg::*;
#(
    parameter int CONV_CYC = `APS_CONV_CYC
)(
    input  wire logic     clk,          // conversion clock, 50 MHz
    input  wire logic     resetn,       // reset, active low: synchronous on clk, asynchronous for cfg_word_q and sd_tog_q on the sclk side
    input  wire logic     sclk,         // shift clock from host
    input  wire logic     cs_n,         // chip select from host, active low
    input  wire logic     din,          // serial config data, msb first
    output aps_cfg_t      cfg_word_q,   // last captured config word (sclk domain)
    output logic          powered_down, // shutdown state flag
    output logic          dummy_busy,   // dummy conversion running
    output logic          wake_pulse    // one clk pulse when powering up
);
    // the dummy counter is 16 bits wide, so longer conversions cannot be served
    if (CONV_CYC < 1 || CONV_CYC > 65535)
    begin : g_bad_conv
        $error("CONV_CYC out of range");
    end

    // link side: shift register, bit counter, request toggle
    logic [4:0]   bit_cnt_q, bit_cnt_d;
    logic [6:0]   shift_q, shift_d;
    aps_cfg_t     cfg_d;
    logic         sd_tog_q, sd_tog_d;

    always_comb
    begin
        bit_cnt_d = bit_cnt_q;
        shift_d   = shift_q;
        cfg_d     = cfg_word_q;
        if (bit_cnt_q != 5'h1F)
            bit_cnt_d = bit_cnt_q + 5'h01;
        if (bit_cnt_q < 5'(`APS_CFG_BITS - 1))
            shift_d = {shift_q[5:0], din};
        if (bit_cnt_q == 5'(`APS_CFG_BITS - 1))
            cfg_d = aps_cfg_t'({shift_q, din});
    end

    // counter is cleared and held at zero while select is high, so a frame starts at zero
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            bit_cnt_q <= 5'h00;
            shift_q   <= 7'h00;
        end
        else
        begin
            bit_cnt_q <= bit_cnt_d;
            shift_q   <= shift_d;
        end
    end

    always_ff @(posedge sclk or negedge resetn)
    begin
        if (!resetn)
            cfg_word_q <= aps_cfg_t'(8'h00);
        else
            cfg_word_q <= cfg_d;
    end

    always_comb
    begin
        sd_tog_d = sd_tog_q;
        if (!cs_n && bit_cnt_q == 5'(`APS_SD_EDGE)
            && {cfg_word_q.length_sel_hi, cfg_word_q.length_sel_lo} == `APS_LEN_SD)
            sd_tog_d = ~sd_tog_q;
    end

    always_ff @(negedge sclk or negedge resetn)
    begin
        if (!resetn)
            sd_tog_q <= 1'b0;
        else
            sd_tog_q <= sd_tog_d;
    end

    // clk side: synchronisers and power state
    // sclk is sampled as data here: a wake burst must span a few clk periods or it can slip by unseen
    logic [2:0]   s1_q, s2_q, prev_q;   // {toggle, sclk, cs_n}
    aps_state_t   st_q, st_d;
    logic [15:0]  cnt_q, cnt_d;
    logic         pd_d, busy_d, wake_d;
    logic         tog_ev, sck_rise, cs_fall, wake_ev;

    assign tog_ev   = s2_q[2] ^ prev_q[2];
    assign sck_rise = s2_q[1] & ~prev_q[1];
    assign cs_fall  = ~s2_q[0] & prev_q[0];
    assign wake_ev  = cs_fall | (sck_rise & ~s2_q[0]);

    always_comb
    begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        wake_d = 1'b0;
        case (st_q)
            ST_RUN:
            begin
                if (tog_ev)
                begin
                    st_d  = ST_DUMMY;
                    cnt_d = 16'(CONV_CYC - 1);
                end
            end
            ST_DUMMY:
            begin
                // requests during the dummy conversion are not seen
                if (cnt_q == 16'h0000)
                    st_d = ST_DOWN;
                else
                    cnt_d = cnt_q - 16'h0001;
            end
            ST_DOWN:
            begin
                if (wake_ev)
                begin
                    st_d   = ST_RUN;
                    wake_d = 1'b1;
                end
            end
            default:
                st_d = ST_RUN;
        endcase
        pd_d   = (st_d != ST_RUN);
        busy_d = (st_d == ST_DUMMY);
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            s1_q         <= 3'h1;
            s2_q         <= 3'h1;
            prev_q       <= 3'h1;
            st_q         <= ST_RUN;
            cnt_q        <= 16'h0000;
            powered_down <= 1'b0;
            dummy_busy   <= 1'b0;
            wake_pulse   <= 1'b0;
        end
        else
        begin
            s1_q         <= {sd_tog_q, sclk, cs_n};
            s2_q         <= s1_q;
            prev_q       <= s2_q;
            st_q         <= st_d;
            cnt_q        <= cnt_d;
            powered_down <= pd_d;
            dummy_busy   <= busy_d;
            wake_pulse   <= wake_d;
        end
    end

    // checks on the clk domain
    property p_sd_enter;
        @(posedge clk) disable iff (!resetn)
        st_q == ST_RUN && tog_ev |=> st_q == ST_DUMMY && powered_down && dummy_busy;
    endproperty
    a_sd_enter: assert property (p_sd_enter) else $error("shutdown not entered");

    property p_dummy_end;
        @(posedge clk) disable iff (!resetn)
        st_q == ST_DUMMY && cnt_q == 16'h0000 |=> st_q == ST_DOWN && !dummy_busy && powered_down;
    endproperty
    a_dummy_end: assert property (p_dummy_end) else $error("dummy conversion did not end");

    property p_dummy_hold;
        @(posedge clk) disable iff (!resetn)
        st_q == ST_DUMMY && cnt_q != 16'h0000 |=> st_q == ST_DUMMY && cnt_q == $past(cnt_q) - 16'h0001;
    endproperty
    a_dummy_hold: assert property (p_dummy_hold) else $error("dummy conversion cut short");

    // state, flag and pulse are all registered from the same next values, so they move together
    property p_wake;
        @(posedge clk) disable iff (!resetn)
        st_q == ST_DOWN && cs_fall |=> st_q == ST_RUN && !powered_down && wake_pulse;
    endproperty
    a_wake: assert property (p_wake) else $error("select did not wake");

    property p_sclk_wake;
        @(posedge clk) disable iff (!resetn)
        st_q == ST_DOWN && sck_rise && !s2_q[0] |=> st_q == ST_RUN && wake_pulse && !powered_down;
    endproperty
    a_sclk_wake: assert property (p_sclk_wake) else $error("late shift clock did not wake");

    property p_flag_hold;
        @(posedge clk) disable iff (!resetn)
        st_q == ST_DOWN && !wake_ev |=> st_q == ST_DOWN && powered_down && !wake_pulse;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without request");

    property p_wake_cause;
        @(posedge clk) disable iff (!resetn)
        $rose(wake_pulse) |-> $past(st_q) == ST_DOWN && $past(wake_ev);
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake without request");

    // checks on the link domain
    property p_code;
        @(negedge sclk) disable iff (!resetn)
        !cs_n && bit_cnt_q == 5'(`APS_SD_EDGE) && !cfg_word_q.length_sel_hi && cfg_word_q.length_sel_lo
        |=> sd_tog_q != $past(sd_tog_q);
    endproperty
    a_code: assert property (p_code) else $error("shutdown code not taken");

    property p_nocode;
        @(negedge sclk) disable iff (!resetn)
        {cfg_word_q.length_sel_hi, cfg_word_q.length_sel_lo} != `APS_LEN_SD |=> $stable(sd_tog_q);
    endproperty
    a_nocode: assert property (p_nocode) else $error("shutdown without code");

    property p_cfg;
        @(posedge sclk) disable iff (!resetn || cs_n)
        bit_cnt_q == 5'(`APS_CFG_BITS - 1) |=> cfg_word_q == aps_cfg_t'({$past(shift_q), $past(din)});
    endproperty
    a_cfg: assert property (p_cfg) else $error("config word not captured");

    c_enter: cover property (@(posedge clk) st_q == ST_DUMMY ##1 st_q == ST_DOWN);
    c_cs_wake: cover property (@(posedge clk) st_q == ST_DOWN && cs_fall);
    c_sclk_wake: cover property (@(posedge clk) st_q == ST_DOWN && sck_rise && !s2_q[0]);
endmodule : aps_shutdown

/* verif/aps_host.sv */
// host serial port model: select, shift clock and config data
module aps_host;
    timeunit 1ns;
    timeprecision 100ps;
    logic sclk = 1'b0; // idle low, stands still between frames
    logic cs_n = 1'b1; // select, active low
    logic din  = 1'b0; // config data, changed on falling edge
    // n clocks of word w; keep leaves select low for a later burst
    task automatic frame(input logic [7:0] w, input int n, input bit keep);
        if (cs_n)
        begin
            cs_n = 1'b0;
            #15;
        end
        for (int i = 0; i < n; i++)
        begin
            din = (i < 8) ? w[7 - i] : ~din;
            #7.5 sclk = 1'b1;
            #7.5 sclk = 1'b0;
        end
        // let the tenth falling edge be taken before select rises and clears the count
        #1;
        din = ~din;
        if (!keep)
            cs_n = 1'b1;
        #15;
    endtask : frame
endmodule : aps_host

/* verif/aps_shutdown_bench.sv */
// self-checking bench for the power shutdown control
module aps_shutdown_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import aps_pkg::*;
    localparam int CONV = 8;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    aps_cfg_t    cfg;
    logic        pd, busy, wake, pd_p = 1'b0;
    int          n_errors = 0, cmp_count = 0, bcnt = 0;
    logic [31:0] rs = 32'h39;
    logic [7:0]  w;
    logic [1:0]  notes[$]; // 1 = entry, 2 = wake
    always #10 clk = ~clk;
    aps_host aps_host_i();
    aps_shutdown #(.CONV_CYC(CONV)) aps_shutdown_i(.clk(clk), .resetn(resetn), .sclk(aps_host_i.sclk),
        .cs_n(aps_host_i.cs_n), .din(aps_host_i.din), .cfg_word_q(cfg), .powered_down(pd),
        .dummy_busy(busy), .wake_pulse(wake));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic note(input bit ok, input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (!ok)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : note
    task automatic cmp_ev(input logic [1:0] g, input logic [1:0] e);
        note(g === e, g, e);
    endtask : cmp_ev
    task automatic cmp_cfg(input aps_cfg_t g, input logic [7:0] e);
        note(g === e, g, e);
    endtask : cmp_cfg
    task automatic cmp_len(input int g, input int e);
        note(g == e, g, e);
    endtask : cmp_len
    task automatic summarize;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    task automatic take(input logic [1:0] code);
        if (notes.size() == 0)
            cmp_ev(code, 2'h0);
        else
            cmp_ev(code, notes.pop_front());
    endtask : take
    // watcher: every event must match the oldest note
    always @(posedge clk)
        if (resetn)
        begin
            if (pd && !pd_p)
                take(2'h1);
            if (wake)
            begin
                take(2'h2);
                cmp_ev({wake, pd}, 2'h2);
            end
            if (busy)
                bcnt++;
            else if (bcnt != 0)
            begin
                cmp_len(bcnt, CONV);
                bcnt = 0;
            end
            pd_p = pd;
        end
    initial
    begin
        repeat (8) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        // all four length codes; only 01 powers down, the next frame wakes
        for (int c = 0; c < 4; c++)
        begin
            rs = xs(rs);
            w = {rs[7:2], 2'(c)};
            if (c == 1)
                notes.push_back(2'h1);
            if (c == 2)
                notes.push_back(2'h2);
            aps_host_i.frame(w, 10, 1'b0);
            cmp_cfg(cfg, w);
            repeat (CONV + 20) @(posedge clk);
            #1;
            cmp_ev({busy, pd}, (c == 1) ? 2'h1 : 2'h0);
        end
        // select held low: late shift clocks after the dummy wake it
        notes.push_back(2'h1);
        aps_host_i.frame(8'h3D, 10, 1'b1);
        repeat (CONV + 20) @(posedge clk);
        #1;
        notes.push_back(2'h2);
        aps_host_i.frame(rs[15:8], 6, 1'b0);
        repeat (20) @(posedge clk);
        #1;
        cmp_len(notes.size(), 0);
        summarize();
    end
    initial
    begin
        #200000;
        n_errors++;
        summarize();
    end
endmodule : aps_shutdown_bench
